// File: hdl/spce_regs.svh
// Register map, field positions, reset values and timing for the serial control slice.
// Included by the shifter and by every design file that decodes registers.
`ifndef SPCE_REGS_SVH
`define SPCE_REGS_SVH
`define SPCE_OFF_CTRL1 12'h000
`define SPCE_OFF_STAT 12'h004
`define SPCE_OFF_DATA 12'h008
`define SPCE_CTRL1_RESET 8'h00
`define SPCE_BIT_XIE 7
`define SPCE_BIT_EN 6
`define SPCE_BIT_TXIE 5
`define SPCE_BIT_ROLE 4
`define SPCE_BIT_TC 7
`define SPCE_BIT_MF 4
`define SPCE_BIT_TE 5
`define SPCE_DIV_LAST 3'h3
`define SPCE_BITS_LAST 3'h7
`endif

// File: hdl/spce_pkg.sv
// Types shared by the serial control slice.
// Assumes spce_regs.svh is on the include path.
package spce_pkg;
    typedef enum logic {SPCE_IDLE, SPCE_RUN} spce_phase_t;

    typedef struct packed {
        logic [2:0] sck_sy;
        logic [2:0] mosi_sy;
        logic [2:0] miso_sy;
        logic [2:0] ss_sy;
        logic sck_lvl;
        logic ss_low;
        spce_phase_t phase;
        logic [7:0] shreg;
        logic [2:0] cnt;
        logic [2:0] div;
        logic rbit;
        logic sck_out;
        logic done;
        logic [7:0] rxb;
    } spce_shift_t;

    typedef struct packed {
        logic [7:0] ctrl;
        logic tc;
        logic mf;
        logic te;
        logic [7:0] txbuf;
        logic txpend;
        logic [7:0] rxbuf;
        logic start;
        logic idle;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic sck_o;
        logic sck_oe_n;
        logic mosi_o;
        logic mosi_oe_n;
        logic miso_o;
        logic miso_oe_n;
    } spce_ctrl_t;
endpackage : spce_pkg

// File: hdl/spce_shift.sv
// Byte shifter for the serial link, mode 0 (clock idles low; slave samples on rise, master at the fall).
// Assumes pins arrive unsynchronised; link clock from a master is sampled here.
`timescale 1ns/1ps
`include "spce_regs.svh"
module spce_shift (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic master,
    input wire logic idle_force,
    input wire logic start,
    input wire logic [7:0] tx_byte,
    input wire logic sck_pin,
    input wire logic mosi_pin,
    input wire logic miso_pin,
    input wire logic ss_n_pin,
    output logic busy,
    output logic done,
    output logic [7:0] rx_byte,
    output logic sck_drv,
    output logic data_drv,
    output logic ss_low
);
    spce_pkg::spce_shift_t s_q, s_d;
    logic rise, fall, tick, ser_in, in_bit;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        s_d.sck_sy = {s_q.sck_sy[1:0], sck_pin};
        s_d.mosi_sy = {s_q.mosi_sy[1:0], mosi_pin};
        s_d.miso_sy = {s_q.miso_sy[1:0], miso_pin};
        s_d.ss_sy = {s_q.ss_sy[1:0], ss_n_pin};
        // Level accepted only once stages two and three agree
        if (s_q.sck_sy[1] == s_q.sck_sy[2]) begin
            s_d.sck_lvl = s_q.sck_sy[2];
        end
        if (s_q.ss_sy[1] == s_q.ss_sy[2]) begin
            s_d.ss_low = ~s_q.ss_sy[2];
        end
        ser_in = master ? s_q.miso_sy[2] : s_q.mosi_sy[2];
        // Master takes its bit at the fall: returned data lags its clock by pin and sync delay
        in_bit = master ? ser_in : s_q.rbit;
        tick = 1'b0;
        rise = 1'b0;
        fall = 1'b0;
        if (master) begin
            tick = (s_q.div == `SPCE_DIV_LAST);
            s_d.div = tick ? 3'h0 : s_q.div + 3'h1;
            rise = tick && !s_q.sck_out;
            fall = tick && s_q.sck_out;
        end else begin
            rise = s_d.sck_lvl && !s_q.sck_lvl && s_q.ss_low;
            fall = !s_d.sck_lvl && s_q.sck_lvl && s_q.ss_low;
        end
        if (start) begin
            s_d.shreg = tx_byte;
            s_d.cnt = 3'h0;
            s_d.div = 3'h0;
            s_d.sck_out = 1'b0;
            s_d.phase = spce_pkg::SPCE_RUN;
        end else if (s_q.phase == spce_pkg::SPCE_RUN) begin
            if (rise) begin
                s_d.rbit = ser_in;
                s_d.sck_out = master;
            end
            if (fall) begin
                s_d.sck_out = 1'b0;
                s_d.shreg = {s_q.shreg[6:0], in_bit};
                s_d.cnt = s_q.cnt + 3'h1;
                if (s_q.cnt == `SPCE_BITS_LAST) begin
                    s_d.rxb = {s_q.shreg[6:0], in_bit};
                    s_d.done = 1'b1;
                    s_d.phase = spce_pkg::SPCE_IDLE;
                end
            end
        end
        // Slave deselect drops a partial byte
        if (!master && !s_q.ss_low) begin
            s_d.cnt = 3'h0;
        end
        if (idle_force || !enable) begin // see R3 see R6
            s_d.phase = spce_pkg::SPCE_IDLE;
            s_d.cnt = 3'h0;
            s_d.sck_out = 1'b0;
            s_d.done = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
            // Select idles high; zeros here would read as a select after reset
            s_q.ss_sy <= '1;
        end else begin
            s_q <= s_d;
        end
    end

    assign busy = (s_q.phase == spce_pkg::SPCE_RUN);
    assign done = s_q.done;
    assign rx_byte = s_q.rxb;
    assign sck_drv = s_q.sck_out;
    assign data_drv = s_q.shreg[7];
    assign ss_low = s_q.ss_low;
endmodule : spce_shift

// File: hdl/spce_ctrl.sv
// Control slice of the serial interface: first control register, status,
// data, interrupt request and pin ownership, reached over APB.
// Assumes an APB master on mclk and raw pins from outside the clock domain.
//
// Function
// R1 - Interrupt enable passes transfer-complete and mode-fault
// R2 - Enable runs interface and takes port pins
// R3 - Clearing enable idles logic, resets status
// R4 - Transmit interrupt enable passes buffer-empty flag
// R5 - Role bit: zero slave, one master
// R6 - Any role change forces transfer logic idle
// R7 - One request output while enabled flag set
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "spce_regs.svh"
module spce_ctrl (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    output logic irq,
    input wire logic sck_i,
    output logic sck_o,
    output logic sck_oe_n,
    input wire logic mosi_i,
    output logic mosi_o,
    output logic mosi_oe_n,
    input wire logic miso_i,
    output logic miso_o,
    output logic miso_oe_n,
    input wire logic ss_n_i
);
    spce_pkg::spce_ctrl_t r_q, r_d;
    logic busy, done, sck_drv, data_drv, ss_low;
    logic [7:0] rx_byte;
    logic acc, wr, rd, en, role, hit;

    spce_shift u_shift (
        .mclk(mclk),
        .rst_n(rst_n),
        .enable(r_q.ctrl[`SPCE_BIT_EN]),
        .master(r_q.ctrl[`SPCE_BIT_ROLE]),
        .idle_force(r_q.idle),
        .start(r_q.start),
        .tx_byte(r_q.txbuf),
        .sck_pin(sck_i),
        .mosi_pin(mosi_i),
        .miso_pin(miso_i),
        .ss_n_pin(ss_n_i),
        .busy(busy),
        .done(done),
        .rx_byte(rx_byte),
        .sck_drv(sck_drv),
        .data_drv(data_drv),
        .ss_low(ss_low)
    );

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        r_d = r_q;
        en = r_q.ctrl[`SPCE_BIT_EN];
        role = r_q.ctrl[`SPCE_BIT_ROLE];
        // One wait state: answer registered on the first access cycle
        acc = psel && penable && r_q.pready;
        wr = acc && pwrite;
        rd = acc && !pwrite;
        hit = (paddr == `SPCE_OFF_CTRL1) || (paddr == `SPCE_OFF_STAT) ||
              (paddr == `SPCE_OFF_DATA);
        r_d.pready = psel && penable && !r_q.pready;
        r_d.pslverr = psel && penable && !r_q.pready && !hit;
        r_d.prdata = 32'h0000_0000;
        if (psel && penable && !r_q.pready && !pwrite) begin
            case (paddr)
                `SPCE_OFF_CTRL1: r_d.prdata = {24'h00_0000, r_q.ctrl};
                `SPCE_OFF_STAT: begin
                    r_d.prdata[`SPCE_BIT_TC] = r_q.tc;
                    r_d.prdata[`SPCE_BIT_MF] = r_q.mf;
                    r_d.prdata[`SPCE_BIT_TE] = r_q.te;
                end
                `SPCE_OFF_DATA: r_d.prdata = {24'h00_0000, r_q.rxbuf};
                default: r_d.prdata = 32'h0000_0000;
            endcase
        end
        r_d.idle = 1'b0;
        r_d.start = 1'b0;
        // Clears first, hardware sets afterwards so a coincident event wins
        if (rd && paddr == `SPCE_OFF_DATA) begin
            r_d.tc = 1'b0;
        end
        if (wr && paddr == `SPCE_OFF_STAT && pwdata[`SPCE_BIT_MF]) begin
            r_d.mf = 1'b0;
        end
        if (wr && paddr == `SPCE_OFF_DATA && en) begin
            r_d.txbuf = pwdata[7:0];
            r_d.txpend = 1'b1;
            r_d.te = 1'b0;
        end
        if (wr && paddr == `SPCE_OFF_CTRL1) begin
            r_d.ctrl = pwdata[7:0];
            if (pwdata[`SPCE_BIT_ROLE] != role) begin
                r_d.idle = 1'b1; // see R6
            end
        end
        if (en && r_q.txpend && !busy && !r_q.start && !r_q.idle) begin
            r_d.start = 1'b1;
            r_d.txpend = 1'b0;
            r_d.te = 1'b1;
        end
        if (done) begin
            r_d.tc = 1'b1;
            r_d.rxbuf = rx_byte;
        end
        // Master sees select pulled low by another master
        if (en && role && ss_low) begin
            r_d.mf = 1'b1;
        end
        if (!r_d.ctrl[`SPCE_BIT_EN]) begin // see R3
            r_d.tc = 1'b0;
            r_d.mf = 1'b0;
            r_d.te = 1'b1;
            r_d.txpend = 1'b0;
            r_d.start = 1'b0;
            r_d.idle = 1'b1;
        end
        r_d.irq = en && ((r_q.ctrl[`SPCE_BIT_XIE] && (r_q.tc || r_q.mf)) || // see R1 see R7
                  (r_q.ctrl[`SPCE_BIT_TXIE] && r_q.te)); // see R4
        // Pins released while disabled; role picks the driven set
        r_d.sck_o = sck_drv;
        r_d.mosi_o = data_drv;
        r_d.miso_o = data_drv;
        r_d.sck_oe_n = !(en && role); // see R2 see R5
        r_d.mosi_oe_n = !(en && role);
        r_d.miso_oe_n = !(en && !role && ss_low); // see R5
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            r_q <= '0;
            r_q.ctrl <= `SPCE_CTRL1_RESET;
            r_q.te <= 1'b1;
            r_q.sck_oe_n <= 1'b1;
            r_q.mosi_oe_n <= 1'b1;
            r_q.miso_oe_n <= 1'b1;
        end else begin
            r_q <= r_d;
        end
    end

    assign pready = r_q.pready;
    assign prdata = r_q.prdata;
    assign pslverr = r_q.pslverr;
    assign irq = r_q.irq;
    assign sck_o = r_q.sck_o;
    assign sck_oe_n = r_q.sck_oe_n;
    assign mosi_o = r_q.mosi_o;
    assign mosi_oe_n = r_q.mosi_oe_n;
    assign miso_o = r_q.miso_o;
    assign miso_oe_n = r_q.miso_oe_n;

    ////////////////////////////////////////////////////////////////////////////
    a_xfer_irq_on: assert property (@(posedge mclk) disable iff (!rst_n) // see R1
        (r_q.ctrl[`SPCE_BIT_EN] && r_q.ctrl[`SPCE_BIT_XIE] && (r_q.tc || r_q.mf)) |=> irq)
        else $error("flag with enable gave no request");
    a_irq_masked: assert property (@(posedge mclk) disable iff (!rst_n) // see R1
        (!r_q.ctrl[`SPCE_BIT_XIE] && !r_q.ctrl[`SPCE_BIT_TXIE]) |=> !irq)
        else $error("request with both enables clear");
    a_pins_taken: assert property (@(posedge mclk) disable iff (!rst_n) // see R2
        (r_q.ctrl[`SPCE_BIT_EN] && r_q.ctrl[`SPCE_BIT_ROLE]) |=> (!sck_oe_n && !mosi_oe_n))
        else $error("enabled master not driving pins");
    a_disable_clr: assert property (@(posedge mclk) disable iff (!rst_n) // see R3
        $fell(r_q.ctrl[`SPCE_BIT_EN]) |-> (!r_q.tc && !r_q.mf && r_q.te && r_q.idle)
            ##1 !busy)
        else $error("disable left status or transfer");
    a_tx_irq_on: assert property (@(posedge mclk) disable iff (!rst_n) // see R4
        (r_q.ctrl[`SPCE_BIT_EN] && r_q.ctrl[`SPCE_BIT_TXIE] && r_q.te) |=> irq)
        else $error("empty buffer gave no request");
    a_slave_pins: assert property (@(posedge mclk) disable iff (!rst_n) // see R5
        !r_q.ctrl[`SPCE_BIT_ROLE] |=> (sck_oe_n && mosi_oe_n))
        else $error("slave drives clock or master data");
    a_role_idle: assert property (@(posedge mclk) disable iff (!rst_n) // see R6
        $changed(r_q.ctrl[`SPCE_BIT_ROLE]) |-> r_q.idle ##1 !busy)
        else $error("role change did not idle transfer");
    a_irq_hold: assert property (@(posedge mclk) disable iff (!rst_n) // see R7
        (r_q.ctrl[`SPCE_BIT_EN] && r_q.ctrl[`SPCE_BIT_XIE] && r_q.mf)[*2] |-> irq)
        else $error("request dropped while flag held");
    // Masking, pin ownership and idle forcing, each path on its own
    a_xfer_masked: assert property (@(posedge mclk) disable iff (!rst_n) // see R1
        (!r_q.ctrl[`SPCE_BIT_XIE] && !r_q.te) |=> !irq)
        else $error("request with flag path masked");
    a_tx_masked: assert property (@(posedge mclk) disable iff (!rst_n) // see R4
        (!r_q.ctrl[`SPCE_BIT_TXIE] && !r_q.tc && !r_q.mf) |=> !irq)
        else $error("request with empty path masked");
    a_off_pins_free: assert property (@(posedge mclk) disable iff (!rst_n) // see R2
        !r_q.ctrl[`SPCE_BIT_EN] |=> (sck_oe_n && mosi_oe_n && miso_oe_n))
        else $error("disabled block drives a pin");
    a_off_quiet: assert property (@(posedge mclk) disable iff (!rst_n) // see R3
        !r_q.ctrl[`SPCE_BIT_EN] |=> !irq)
        else $error("request while disabled");
    a_off_idle: assert property (@(posedge mclk) disable iff (!rst_n) // see R3
        !r_q.ctrl[`SPCE_BIT_EN] |=> !busy)
        else $error("transfer runs while disabled");
    a_off_clk_low: assert property (@(posedge mclk) disable iff (!rst_n) // see R3
        (!r_q.ctrl[`SPCE_BIT_EN])[*2] |=> !sck_o)
        else $error("link clock high while disabled");
    a_start_gated: assert property (@(posedge mclk) disable iff (!rst_n) // see R2
        r_q.start |-> r_q.ctrl[`SPCE_BIT_EN])
        else $error("transfer started while disabled");
    a_master_miso_in: assert property (@(posedge mclk) disable iff (!rst_n) // see R5
        r_q.ctrl[`SPCE_BIT_ROLE] |=> miso_oe_n)
        else $error("master drives its data input");
    a_slave_miso_out: assert property (@(posedge mclk) disable iff (!rst_n) // see R5
        (r_q.ctrl[`SPCE_BIT_EN] && !r_q.ctrl[`SPCE_BIT_ROLE] && ss_low) |=> !miso_oe_n)
        else $error("selected slave not driving data");
    a_idle_stops: assert property (@(posedge mclk) disable iff (!rst_n) // see R6
        r_q.idle |=> !busy)
        else $error("idle pulse left transfer running");
endmodule : spce_ctrl

// File: tb/spce_peer.sv
// Far side: mode 0 serial slave while the block leads, master at 320 ns otherwise.
// Assumes the bench feeds the block's pin outputs in and the wire levels back.
`timescale 1ns/1ps
module spce_peer (
    input wire logic sck_o,
    input wire logic sck_oe_n,
    input wire logic mosi_o,
    input wire logic mosi_oe_n,
    input wire logic miso_o,
    input wire logic miso_oe_n,
    output logic sck_w,
    output logic mosi_w,
    output logic miso_w,
    output logic ss_n,
    output logic [7:0] got
);
    logic pk_sck = 1'b0;
    logic pk_mosi = 1'b0;
    logic pk_miso = 1'b1;
    logic [7:0] sreg = 8'h00;
    initial ss_n = 1'b1;
    initial got = 8'h00;
    // Link clock stands low between frames
    assign sck_w = sck_oe_n ? pk_sck : sck_o;
    assign mosi_w = mosi_oe_n ? pk_mosi : mosi_o;
    assign miso_w = miso_oe_n ? pk_miso : miso_o;
    ////////////////////////////////////////////////////////////////////////////
    task automatic load(input logic [7:0] r);
        sreg <= r;
        pk_miso <= r[7];
    endtask : load
    task automatic sel(input logic v);
        ss_n <= v;
    endtask : sel
    always @(posedge sck_w) if (!sck_oe_n) got = {got[6:0], mosi_w};
    // Junk fill so a late sample never sees a stale bit
    always @(negedge sck_w) begin
        if (!sck_oe_n) begin
            sreg = {sreg[6:0], ~sreg[0]};
            pk_miso = sreg[7];
        end
    end
    // Sampled late in the high phase: pin lags the edge by sync delay
    task automatic mxfer(input logic [7:0] tx, output logic [7:0] rx);
        #7 ss_n = 1'b0;
        #160;
        for (int i = 7; i >= 0; i--) begin
            pk_mosi = tx[i];
            #160 pk_sck = 1'b1;
            #150 rx[i] = miso_w;
            #10 pk_sck = 1'b0;
        end
        #160 ss_n = 1'b1;
        pk_mosi = ~pk_mosi;
    endtask : mxfer
endmodule : spce_peer

// File: tb/spce_ctrl_tb.sv
// Self-checking bench for the serial control slice, flag model beside it.
// Assumes the far-side model in spce_peer.sv.
`timescale 1ns/1ps
module spce_ctrl_tb;
    logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, irq, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd_v, seed;
    logic sck_o, sck_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n;
    logic sck_w, mosi_w, miso_w, ss_n, m_tc, m_mf;
    logic [7:0] got, rx, tx, rp, m_ctrl;
    int bad_count, n_compared;
    spce_ctrl dut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .irq(irq), .sck_i(sck_w), .sck_o(sck_o),
        .sck_oe_n(sck_oe_n), .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe_n(mosi_oe_n),
        .miso_i(miso_w), .miso_o(miso_o), .miso_oe_n(miso_oe_n), .ss_n_i(ss_n));
    spce_peer peer (.sck_o(sck_o), .sck_oe_n(sck_oe_n), .mosi_o(mosi_o),
        .mosi_oe_n(mosi_oe_n), .miso_o(miso_o), .miso_oe_n(miso_oe_n), .sck_w(sck_w),
        .mosi_w(mosi_w), .miso_w(miso_w), .ss_n(ss_n), .got(got));
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // Buffer empty is always back by the time status is read
    function automatic logic [31:0] m_st();
        return {24'h00_0000, m_tc, 1'b0, 1'b1, m_mf, 4'h0};
    endfunction : m_st
    function automatic logic [31:0] m_irq();
        return {31'h0, m_ctrl[6] & ((m_ctrl[7] & (m_tc | m_mf)) | m_ctrl[5])};
    endfunction : m_irq
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            $display("[ERR] %s exp %h seen %h", nm, e, s);
            bad_count++;
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            bad_count++;
            stop_test();
        end
        rd_v = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask : apb
    task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, rd_v, e);
    endtask : rd
    task automatic setc(input logic [7:0] v);
        apb(1'b1, 12'h000, {24'h00_0000, v});
        if (!v[6]) begin
            m_tc = 1'b0;
            m_mf = 1'b0;
        end
        m_ctrl = v;
    endtask : setc
    task automatic ci();
        repeat (2) @(posedge mclk);
        chk("irq", {31'h0, irq}, m_irq());
    endtask : ci
    task automatic wait_tc();
        int n;
        n = 0;
        do begin
            apb(1'b0, 12'h004, 32'h0);
            n++;
        end while (rd_v[7] !== 1'b1 && n < 40);
        if (rd_v[7] !== 1'b1) begin
            bad_count++;
            stop_test();
        end
        m_tc = 1'b1;
    endtask : wait_tc
    task automatic fault();
        peer.sel(1'b0);
        repeat (8) @(posedge mclk);
        m_mf = 1'b1;
        peer.sel(1'b1);
        @(posedge mclk);
    endtask : fault
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {psel, penable, pwrite, paddr, pwdata, rst_n, m_ctrl, m_tc, m_mf} = '0;
        bad_count = 0;
        n_compared = 0;
        seed = 32'hf72a_c8bf;
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        rd("ctrl", 12'h000, 32'h0);
        rd("stat", 12'h004, m_st());
        rd("hole", 12'h00c, 32'h0);
        chk("err", {31'h0, er}, 32'h1);
        chk("pins", {29'h0, sck_oe_n, mosi_oe_n, miso_oe_n}, 32'h7);
        $display("test reset done");
        setc(8'h50);
        @(posedge mclk);
        chk("pins", {29'h0, sck_oe_n, mosi_oe_n, miso_oe_n}, 32'h1);
        seed = lfsr(seed);
        tx = seed[7:0];
        rp = seed[15:8];
        peer.load(rp);
        apb(1'b1, 12'h008, {24'h00_0000, tx});
        wait_tc();
        ci();
        chk("mosi", {24'h00_0000, got}, {24'h00_0000, tx});
        setc(8'hd0);
        ci();
        rd("data", 12'h008, {24'h00_0000, rp});
        m_tc = 1'b0;
        ci();
        setc(8'h70);
        ci();
        setc(8'h50);
        ci();
        $display("test master done");
        setc(8'hd0);
        fault();
        rd("stat", 12'h004, m_st());
        ci();
        apb(1'b1, 12'h004, 32'h10);
        m_mf = 1'b0;
        ci();
        $display("test fault done");
        apb(1'b1, 12'h008, {24'h00_0000, tx});
        repeat (20) @(posedge mclk);
        setc(8'h40);
        repeat (100) @(posedge mclk);
        rd("stat", 12'h004, m_st());
        chk("sck_oe", {31'h0, sck_oe_n}, 32'h1);
        $display("test role done");
        seed = lfsr(seed);
        tx = seed[23:16];
        rp = seed[7:0];
        apb(1'b1, 12'h008, {24'h00_0000, tx});
        peer.mxfer(rp, rx);
        @(posedge mclk);
        chk("miso", {24'h00_0000, rx}, {24'h00_0000, tx});
        wait_tc();
        rd("data", 12'h008, {24'h00_0000, rp});
        m_tc = 1'b0;
        $display("test slave done");
        setc(8'h50);
        fault();
        setc(8'h10);
        rd("stat", 12'h004, m_st());
        chk("pins", {29'h0, sck_oe_n, mosi_oe_n, miso_oe_n}, 32'h7);
        $display("test disable done");
        stop_test();
    end
endmodule : spce_ctrl_tb
